// ==== verilog/branch_trace_debug_regs.sv ====
// branch trace on status and data pins plus debug register access
// How it works
// - taken branch drives status code 0x5
// - capture targets only for variant-addressed flow changes
// - marker on status pins precedes data output
// - two, three or four bytes selectable
// - bytes least first, one nibble per cycle
// - two-byte case: 0x5, then 0x9, four nibbles
// - fifo lets status run ahead of data
// - full fifo stalls pipeline showing continue code
// - registers reachable by serial port and core
// - inhibit bit blocks core breakpoint writes
// - registers accessed as 32-bit words
// - config register write-only from core side
// - five-bit select; some codes reserved
// - defined reset values for control registers
// - markers 0x9, 0xa, 0xb pick length
`timescale 1ns/100ps
module branch_trace_debug_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // instruction retire stream from the core
  input wire logic i_instr_valid,
  input wire logic i_instr_taken_branch,
  input wire logic i_instr_variant_target,
  input wire logic [31:0] i_instr_target,
  input wire logic [3:0] i_instr_status,
  output logic o_pipeline_stall,
  // trace pins
  output logic [3:0] o_processor_status_pins,
  output logic [3:0] o_debug_data_pins,
  // serial debug port register commands
  input wire logic i_read_debug_reg_command,
  input wire logic i_write_debug_reg_command,
  input wire logic [4:0] i_debug_reg_select,
  input wire logic [31:0] i_port_wdata,
  output logic [31:0] o_port_rdata,
  output logic o_port_rvalid,
  output logic o_port_select_error,
  // core debug-write instruction
  input wire logic i_debug_write_instruction,
  input wire logic i_core_supervisor,
  input wire logic [4:0] i_core_select,
  input wire logic [31:0] i_core_wdata,
  output logic o_core_write_blocked
);
  logic [31:0] config_status;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [1:0] byte_sel;
  logic capture;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_pop;
  logic [31:0] head_addr;
  logic [1:0] head_bytes;
  trace_debug_pkg::out_state_type out_state_r;
  trace_debug_pkg::out_state_type out_state_nxt;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [2:0] nib_left_r;
  logic [2:0] nib_left_nxt;
  logic [3:0] status_r;
  logic [3:0] status_nxt;
  logic [3:0] data_r;
  logic [3:0] data_nxt;
  logic mark_hold;
  logic bypass;
  logic push;
  logic [3:0] mark_code_r;
  logic [31:0] port_rdata_r;
  logic port_rvalid_r;
  logic port_err_r;

  function automatic logic [3:0] marker_for(input logic [1:0] bytes);
    unique case (bytes)
      trace_debug_pkg::BYTES_THREE: marker_for = trace_debug_pkg::PST_MARK_3BYTE;
      trace_debug_pkg::BYTES_FOUR: marker_for = trace_debug_pkg::PST_MARK_4BYTE;
      default: marker_for = trace_debug_pkg::PST_MARK_2BYTE;
    endcase
  endfunction : marker_for

  // count runs down to zero, so one less than the nibbles sent
  function automatic logic [2:0] nibbles_for(input logic [1:0] bytes);
    unique case (bytes)
      trace_debug_pkg::BYTES_THREE: nibbles_for = 3'h5;
      trace_debug_pkg::BYTES_FOUR: nibbles_for = 3'h7;
      default: nibbles_for = 3'h3;
    endcase
  endfunction : nibbles_for

  debug_reg_bank u_regs (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_port_wr(i_write_debug_reg_command),
    .i_port_sel(i_debug_reg_select),
    .i_port_wdata(i_port_wdata),
    .i_core_wr(i_debug_write_instruction),
    .i_core_supervisor(i_core_supervisor),
    .i_core_sel(i_core_select),
    .i_core_wdata(i_core_wdata),
    .i_rd_sel(i_debug_reg_select),
    .o_rd_data(rd_data),
    .o_rd_valid_sel(rd_ok),
    .o_config_status(config_status),
    .o_core_wr_blocked(o_core_write_blocked)
  );

  assign byte_sel = config_status[trace_debug_pkg::CSR_BYTES_LSB +: 2];
  // only variant-addressed branches carry a target worth showing
  assign capture = i_instr_valid && i_instr_taken_branch && i_instr_variant_target &&
                   (byte_sel != trace_debug_pkg::BYTES_NONE);
  // a marker owns the status pins for its cycle, so a branch then waits
  assign mark_hold = (out_state_r == trace_debug_pkg::OUT_MARK) && i_instr_valid &&
                     i_instr_taken_branch;
  // stall rather than drop a target when the fifo has no room
  assign o_pipeline_stall = (capture && fifo_full) || mark_hold;
  assign fifo_pop = (out_state_r == trace_debug_pkg::OUT_IDLE) && !fifo_empty;
  // idle and empty: marker follows the branch code at once
  assign bypass = capture && fifo_empty && (out_state_r == trace_debug_pkg::OUT_IDLE);
  assign push = capture && !o_pipeline_stall && !bypass;

  trace_fifo u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_push(push),
    .i_push_addr(i_instr_target),
    .i_push_bytes(byte_sel),
    .i_pop(fifo_pop),
    .o_head_addr(head_addr),
    .o_head_bytes(head_bytes),
    .o_full(fifo_full),
    .o_empty(fifo_empty)
  );

  // status pins: marker goes out whatever the core shows, overriding its status code
  always_comb begin
    status_nxt = trace_debug_pkg::PST_CONTINUE;
    if (out_state_r == trace_debug_pkg::OUT_MARK) begin
      status_nxt = mark_code_r;
    end else if (o_pipeline_stall) begin
      status_nxt = trace_debug_pkg::PST_CONTINUE;
    end else if (i_instr_valid && i_instr_taken_branch) begin
      status_nxt = trace_debug_pkg::PST_TAKEN_BRANCH;
    end else if (i_instr_valid) begin
      status_nxt = i_instr_status;
    end
  end

  // data output sequencer
  always_comb begin
    out_state_nxt = out_state_r;
    shift_nxt = shift_r;
    nib_left_nxt = nib_left_r;
    data_nxt = 4'h0;
    unique case (out_state_r)
      trace_debug_pkg::OUT_IDLE: begin
        if (fifo_pop) begin
          out_state_nxt = trace_debug_pkg::OUT_MARK;
          shift_nxt = head_addr;
          nib_left_nxt = nibbles_for(head_bytes);
        end else if (bypass) begin
          out_state_nxt = trace_debug_pkg::OUT_MARK;
          shift_nxt = i_instr_target;
          nib_left_nxt = nibbles_for(byte_sel);
        end
      end
      trace_debug_pkg::OUT_MARK: begin
        // the marker always goes out; a new branch is stalled instead
        out_state_nxt = trace_debug_pkg::OUT_DATA;
      end
      trace_debug_pkg::OUT_DATA: begin
        data_nxt = shift_r[3:0];
        shift_nxt = {4'h0, shift_r[31:4]};
        nib_left_nxt = nib_left_r - 3'h1;
        if (nib_left_r == 3'h0) begin
          out_state_nxt = trace_debug_pkg::OUT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      out_state_r <= trace_debug_pkg::OUT_IDLE;
      shift_r <= 32'h0000_0000;
      nib_left_r <= 3'h0;
      status_r <= trace_debug_pkg::PST_CONTINUE;
      data_r <= 4'h0;
    end else begin
      out_state_r <= out_state_nxt;
      shift_r <= shift_nxt;
      nib_left_r <= nib_left_nxt;
      status_r <= status_nxt;
      data_r <= data_nxt;
    end
  end

  // marker code latched from the popped or bypassed entry
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mark_code_r <= trace_debug_pkg::PST_MARK_2BYTE;
    end else if (fifo_pop) begin
      mark_code_r <= marker_for(head_bytes);
    end else if (bypass) begin
      mark_code_r <= marker_for(byte_sel);
    end
  end

  // serial read answers one cycle after the command
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_rdata_r <= 32'h0000_0000;
      port_rvalid_r <= 1'b0;
      port_err_r <= 1'b0;
    end else begin
      port_rvalid_r <= i_read_debug_reg_command && rd_ok;
      port_err_r <= (i_read_debug_reg_command || i_write_debug_reg_command) && !rd_ok;
      if (i_read_debug_reg_command) begin
        port_rdata_r <= rd_data;
      end
    end
  end

  assign o_processor_status_pins = status_r;
  assign o_debug_data_pins = data_r;
  assign o_port_rdata = port_rdata_r;
  assign o_port_rvalid = port_rvalid_r;
  assign o_port_select_error = port_err_r;
endmodule : branch_trace_debug_regs

// ==== verilog/trace_debug_pkg.sv ====
// constants for the branch trace and debug register block
package trace_debug_pkg;
  localparam logic [3:0] PST_CONTINUE = 4'h0;
  localparam logic [3:0] PST_BEGIN = 4'h1;
  localparam logic [3:0] PST_TAKEN_BRANCH = 4'h5;
  localparam logic [3:0] PST_MARK_2BYTE = 4'h9;
  localparam logic [3:0] PST_MARK_3BYTE = 4'ha;
  localparam logic [3:0] PST_MARK_4BYTE = 4'hb;
  localparam logic [4:0] SEL_CONFIG_STATUS = 5'h00;
  localparam logic [4:0] SEL_PORT_ATTRIBUTE = 5'h05;
  localparam logic [4:0] SEL_ATTRIBUTE_TRIGGER = 5'h06;
  localparam logic [4:0] SEL_TRIGGER_DEFINITION = 5'h07;
  localparam logic [4:0] SEL_PC_BREAKPOINT = 5'h08;
  localparam logic [4:0] SEL_PC_BREAKPOINT_MASK = 5'h09;
  localparam logic [4:0] SEL_ADDR_BREAKPOINT_HIGH = 5'h0c;
  localparam logic [4:0] SEL_ADDR_BREAKPOINT_LOW = 5'h0d;
  localparam logic [4:0] SEL_DATA_BREAKPOINT = 5'h0e;
  localparam logic [4:0] SEL_DATA_BREAKPOINT_MASK = 5'h0f;
  localparam logic [31:0] RST_CONFIG_STATUS = 32'h0010_0000;
  localparam logic [31:0] RST_PORT_ATTRIBUTE = 32'h0000_0005;
  localparam logic [31:0] RST_ATTRIBUTE_TRIGGER = 32'h0000_0005;
  localparam logic [31:0] RST_TRIGGER_DEFINITION = 32'h0000_0000;
  // field positions in debug_config_status
  localparam int CSR_IPW_BIT = 16;
  localparam int CSR_BYTES_LSB = 8;
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_TWO = 2'h1;
  localparam logic [1:0] BYTES_THREE = 2'h2;
  localparam logic [1:0] BYTES_FOUR = 2'h3;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_PTR_W = 2;
  typedef enum logic [1:0] {
    OUT_IDLE,
    OUT_MARK,
    OUT_DATA
  } out_state_type;
endpackage : trace_debug_pkg

// ==== verilog/trace_fifo.sv ====
// small fifo holding captured target addresses and their byte counts
`timescale 1ns/100ps
module trace_fifo (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_push,
  input wire logic [31:0] i_push_addr,
  input wire logic [1:0] i_push_bytes,
  input wire logic i_pop,
  output logic [31:0] o_head_addr,
  output logic [1:0] o_head_bytes,
  output logic o_full,
  output logic o_empty
);
  logic [31:0] addr_mem [trace_debug_pkg::FIFO_DEPTH];
  logic [1:0] bytes_mem [trace_debug_pkg::FIFO_DEPTH];
  logic [trace_debug_pkg::FIFO_PTR_W-1:0] wr_ptr_r;
  logic [trace_debug_pkg::FIFO_PTR_W-1:0] rd_ptr_r;
  logic [trace_debug_pkg::FIFO_PTR_W:0] count_r;
  wire do_push = i_push && !o_full;
  wire do_pop = i_pop && !o_empty;

  assign o_full = (count_r == 3'(trace_debug_pkg::FIFO_DEPTH));
  assign o_empty = (count_r == 3'h0);
  assign o_head_addr = addr_mem[rd_ptr_r];
  assign o_head_bytes = bytes_mem[rd_ptr_r];

  always_ff @(posedge i_sys_clk) begin
    if (do_push) begin
      addr_mem[wr_ptr_r] <= i_push_addr;
      bytes_mem[wr_ptr_r] <= i_push_bytes;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + 2'(do_push);
      rd_ptr_r <= rd_ptr_r + 2'(do_pop);
      count_r <= count_r + 3'(do_push) - 3'(do_pop);
    end
  end
endmodule : trace_fifo

// ==== verilog/debug_reg_bank.sv ====
// bank of 32-bit debug registers, reached by serial port and core
`timescale 1ns/100ps
module debug_reg_bank (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_port_wr,
  input wire logic [4:0] i_port_sel,
  input wire logic [31:0] i_port_wdata,
  input wire logic i_core_wr,
  input wire logic i_core_supervisor,
  input wire logic [4:0] i_core_sel,
  input wire logic [31:0] i_core_wdata,
  input wire logic [4:0] i_rd_sel,
  output logic [31:0] o_rd_data,
  output logic o_rd_valid_sel,
  output logic [31:0] o_config_status,
  output logic o_core_wr_blocked
);
  logic [31:0] ctl_r [8];
  logic [31:0] bp_r [8];
  logic inhibit_processor_writes;
  logic core_ok;
  logic wr_en;
  logic [4:0] wr_sel;
  logic [31:0] wr_data;

  function automatic logic is_reserved(input logic [4:0] sel);
    is_reserved = sel[4] || (sel >= 5'h01 && sel <= 5'h04) || sel == 5'h0a || sel == 5'h0b;
  endfunction : is_reserved

  function automatic logic is_breakpoint(input logic [4:0] sel);
    is_breakpoint = (sel >= trace_debug_pkg::SEL_PC_BREAKPOINT) && !is_reserved(sel);
  endfunction : is_breakpoint

  assign inhibit_processor_writes = ctl_r[0][trace_debug_pkg::CSR_IPW_BIT];
  // core writes need supervisor mode, and breakpoints honour the lock
  assign core_ok = i_core_wr && i_core_supervisor && !is_reserved(i_core_sel) &&
                   !(inhibit_processor_writes && is_breakpoint(i_core_sel));
  assign o_core_wr_blocked = i_core_wr && !core_ok;
  // serial port wins; concurrent access is the other party's problem
  assign wr_en = i_port_wr ? !is_reserved(i_port_sel) : core_ok;
  assign wr_sel = i_port_wr ? i_port_sel : i_core_sel;
  assign wr_data = i_port_wr ? i_port_wdata : i_core_wdata;
  assign o_rd_valid_sel = !is_reserved(i_rd_sel);
  assign o_rd_data = !o_rd_valid_sel ? 32'h0000_0000 :
                     i_rd_sel[3] ? bp_r[i_rd_sel[2:0]] : ctl_r[i_rd_sel[2:0]];
  assign o_config_status = ctl_r[0];

  // reserved slots 1 to 4 are never written; they read as zero anyway
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_r[0] <= trace_debug_pkg::RST_CONFIG_STATUS;
      ctl_r[1] <= 32'h0000_0000;
      ctl_r[2] <= 32'h0000_0000;
      ctl_r[3] <= 32'h0000_0000;
      ctl_r[4] <= 32'h0000_0000;
      ctl_r[5] <= trace_debug_pkg::RST_PORT_ATTRIBUTE;
      ctl_r[6] <= trace_debug_pkg::RST_ATTRIBUTE_TRIGGER;
      ctl_r[7] <= trace_debug_pkg::RST_TRIGGER_DEFINITION;
    end else if (wr_en && !wr_sel[3]) begin
      ctl_r[wr_sel[2:0]] <= wr_data;
    end
  end

  // breakpoints carry no reset value
  always_ff @(posedge i_sys_clk) begin
    if (wr_en && wr_sel[3]) begin
      bp_r[wr_sel[2:0]] <= wr_data;
    end
  end
endmodule : debug_reg_bank

// ==== dv/trace_debug_sva.sv ====
// port assertions for the branch trace and debug register block
`timescale 1ns/100ps
module trace_debug_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic i_instr_taken_branch,
  input wire logic o_pipeline_stall,
  input wire logic [3:0] o_processor_status_pins,
  input wire logic i_read_debug_reg_command,
  input wire logic i_write_debug_reg_command,
  input wire logic [4:0] i_debug_reg_select,
  input wire logic [31:0] i_port_wdata,
  input wire logic o_port_rvalid,
  input wire logic o_port_select_error,
  input wire logic i_debug_write_instruction,
  input wire logic i_core_supervisor,
  input wire logic [4:0] i_core_select,
  input wire logic [31:0] i_core_wdata,
  input wire logic o_core_write_blocked
);
  logic [31:0] cfg_r;
  wire rsv = (i_debug_reg_select inside {[5'h01:5'h04], 5'h0a, 5'h0b}) || i_debug_reg_select[4];
  wire csel_ok = !(i_core_select inside {[5'h01:5'h04], 5'h0a, 5'h0b}) && !i_core_select[4];
  wire cmd = i_read_debug_reg_command || i_write_debug_reg_command;
  // shadow of the config register; serial write wins a clash
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= trace_debug_pkg::RST_CONFIG_STATUS;
    end else if (i_write_debug_reg_command && i_debug_reg_select == 5'h00) begin
      cfg_r <= i_port_wdata;
    end else if (i_debug_write_instruction && i_core_supervisor && i_core_select == 5'h00) begin
      cfg_r <= i_core_wdata;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_TAKEN: assert property (
    i_instr_valid && i_instr_taken_branch && !o_pipeline_stall |=> o_processor_status_pins == 4'h5
  ) else $error("taken branch code missing");
  AST_MARKER: assert property (
    o_processor_status_pins inside {4'h9, 4'ha, 4'hb} |->
      o_processor_status_pins == {2'b10, cfg_r[9:8]}
  ) else $error("marker does not match byte count");
  AST_STALL: assert property (
    o_pipeline_stall |-> i_instr_valid && i_instr_taken_branch
      ##1 o_processor_status_pins inside {4'h0, 4'h9, 4'ha, 4'hb}
  ) else $error("stall without capture or wrong status");
  AST_RVALID: assert property (
    i_read_debug_reg_command && !rsv |=> o_port_rvalid && !o_port_select_error
  ) else $error("read not answered");
  AST_SELERR: assert property (
    cmd && rsv |=> o_port_select_error && !o_port_rvalid
  ) else $error("reserved select not refused");
  AST_RV_CAUSE: assert property (
    o_port_rvalid |-> $past(i_read_debug_reg_command) && !$past(rsv)
  ) else $error("read data without a read");
  AST_USER: assert property (
    i_debug_write_instruction && !i_core_supervisor |-> o_core_write_blocked
  ) else $error("user core write not blocked");
  AST_IPW: assert property (
    i_debug_write_instruction && i_core_supervisor && csel_ok && !i_write_debug_reg_command
      |-> o_core_write_blocked == (cfg_r[16] && i_core_select >= 5'h08)
  ) else $error("core write lock wrong");
endmodule : trace_debug_sva
bind branch_trace_debug_regs trace_debug_sva u_sva (.i_sys_clk, .i_rst, .i_instr_valid,
  .i_instr_taken_branch, .o_pipeline_stall, .o_processor_status_pins,
  .i_read_debug_reg_command, .i_write_debug_reg_command, .i_debug_reg_select, .i_port_wdata,
  .o_port_rvalid, .o_port_select_error, .i_debug_write_instruction, .i_core_supervisor,
  .i_core_select, .i_core_wdata, .o_core_write_blocked);

// ==== dv/dev_host.sv ====
// development system model issuing serial register commands
`timescale 1ns/100ps
module dev_host (
  input wire logic i_sys_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_err,
  output logic o_rd,
  output logic o_wr,
  output logic [4:0] o_sel,
  output logic [31:0] o_wdata
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_sel = 5'h00;
    o_wdata = 32'h0;
  end
  // one command at a time, never beside a core write
  task automatic cmd(input logic wr, input logic [4:0] s, input logic [31:0] d,
                     output logic [31:0] q, output logic v, output logic e);
    @(negedge i_sys_clk);
    o_rd = !wr;
    o_wr = wr;
    o_sel = s;
    o_wdata = d;
    @(negedge i_sys_clk);
    o_rd = 1'b0;
    o_wr = 1'b0;
    q = i_rdata;
    v = i_rvalid;
    e = i_err;
    // released lines scrambled so stale values never match
    o_sel = ~s;
    o_wdata = ~d;
  endtask : cmd
endmodule : dev_host

// ==== dv/tb.sv ====
// self-checking bench for branch trace and debug registers
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iv = 1'b0, tk = 1'b0, vt = 1'b0;
  logic [31:0] tg = 32'h0;
  logic [3:0] ist = 4'h1;
  logic stall, rdc, wrc, rv, err, blk;
  logic [3:0] st, dd;
  logic [4:0] sel;
  logic [31:0] wd, rdat;
  logic cwr = 1'b0, csup = 1'b0;
  logic [4:0] csel = 5'h00;
  logic [31:0] cdat = 32'h0;
  int num_errors = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  branch_trace_debug_regs dut (.i_sys_clk(clk), .i_rst(rst), .i_instr_valid(iv),
    .i_instr_taken_branch(tk), .i_instr_variant_target(vt), .i_instr_target(tg),
    .i_instr_status(ist), .o_pipeline_stall(stall), .o_processor_status_pins(st),
    .o_debug_data_pins(dd), .i_read_debug_reg_command(rdc), .i_write_debug_reg_command(wrc),
    .i_debug_reg_select(sel), .i_port_wdata(wd), .o_port_rdata(rdat), .o_port_rvalid(rv),
    .o_port_select_error(err), .i_debug_write_instruction(cwr), .i_core_supervisor(csup),
    .i_core_select(csel), .i_core_wdata(cdat), .o_core_write_blocked(blk));
  dev_host host (.i_sys_clk(clk), .i_rdata(rdat), .i_rvalid(rv), .i_err(err), .o_rd(rdc),
    .o_wr(wrc), .o_sel(sel), .o_wdata(wd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [4:0] s, output logic [31:0] q);
    logic v, e;
    host.cmd(1'b0, s, 32'h0, q, v, e);
    chk(v, 1'b1);
    chk(e, 1'b0);
  endtask : rd
  task automatic wr(input logic [4:0] s, input logic [31:0] d);
    logic [31:0] q;
    logic v, e;
    host.cmd(1'b1, s, d, q, v, e);
    chk(e, 1'b0);
  endtask : wr
  task automatic cw(input logic sup, input logic [4:0] s, input logic [31:0] d, input logic eb);
    @(negedge clk);
    cwr = 1'b1;
    csup = sup;
    csel = s;
    cdat = d;
    #1 chk(blk, eb);
    @(negedge clk);
    cwr = 1'b0;
  endtask : cw
  task automatic t_reset_select;
    logic [31:0] q;
    logic v, e;
    logic [4:0] bad [5] = '{5'h01, 5'h04, 5'h0a, 5'h0b, 5'h10};
    rd(5'h00, q);
    chk(q, trace_debug_pkg::RST_CONFIG_STATUS);
    rd(5'h05, q);
    chk(q, 32'h0000_0005);
    rd(5'h06, q);
    chk(q, 32'h0000_0005);
    rd(5'h07, q);
    chk(q, 32'h0);
    foreach (bad[i]) begin
      host.cmd(i[0], bad[i], 32'h0, q, v, e);
      chk({v, e}, 2'b01);
    end
    $display("test reset_select done");
  endtask : t_reset_select
  task automatic t_regs;
    logic [31:0] q;
    logic [4:0] s [9] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0c, 5'h0d, 5'h0e, 5'h0f};
    foreach (s[i]) begin
      wr(s[i], 32'ha5c3_0f00 ^ {27'h0, s[i]});
      rd(s[i], q);
      chk(q, 32'ha5c3_0f00 ^ {27'h0, s[i]});
    end
    cw(1'b1, 5'h08, 32'h1234_5678, 1'b0);
    rd(5'h08, q);
    chk(q, 32'h1234_5678);
    cw(1'b0, 5'h09, 32'h0, 1'b1);
    rd(5'h09, q);
    chk(q, 32'ha5c3_0f09);
    cw(1'b1, 5'h00, 32'h0000_0100, 1'b0);
    rd(5'h00, q);
    chk(q, 32'h0000_0100);
    wr(5'h00, 32'h0001_0000);
    cw(1'b1, 5'h0c, 32'hffff_ffff, 1'b1);
    rd(5'h0c, q);
    chk(q, 32'ha5c3_0f0c);
    cw(1'b1, 5'h07, 32'h0000_0003, 1'b0);
    rd(5'h07, q);
    chk(q, 32'h0000_0003);
    $display("test regs done");
  endtask : t_regs
  task automatic br(input logic vb, input logic [1:0] nb, input logic [31:0] t);
    int n;
    n = (vb && nb != 2'h0) ? 2 * nb + 2 : 0;
    wr(5'h00, {22'h0, nb, 8'h0});
    @(negedge clk);
    {iv, tk, vt, tg} = {3'b111 & {2'b11, vb}, t};
    @(negedge clk);
    {iv, tk, vt} = 3'b000;
    chk(st, 4'h5);
    @(negedge clk);
    if (n > 0) chk(st, {2'b10, nb});
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      chk(dd, t[4*i+:4]);
    end
    // data pins fall back to zero once the target is out
    repeat (10) begin
      @(negedge clk);
      chk(dd, 4'h0);
    end
  endtask : br
  task automatic t_trace;
    for (int b = 1; b < 4; b++) br(1'b1, b[1:0], 32'h8765_4321 + b);
    br(1'b0, 2'h3, 32'hffff_ffff);
    br(1'b1, 2'h0, 32'hffff_ffff);
    $display("test trace done");
  endtask : t_trace
  task automatic t_fifo;
    logic seen_stall = 1'b0, seen_run = 1'b0;
    wr(5'h00, 32'h0000_0300);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      {iv, tk, vt, tg} = {3'b111, 32'h9abc_def1 + k};
      if (st === 4'h5 && dd !== 4'h0) seen_run = 1'b1;
      #1;
      while (stall === 1'b1) begin
        seen_stall = 1'b1;
        @(negedge clk);
      end
    end
    @(negedge clk);
    {iv, tk, vt} = 3'b000;
    chk(seen_stall, 1'b1);
    chk(seen_run, 1'b1);
    repeat (120) @(negedge clk);
    chk(dd, 4'h0);
    $display("test fifo done");
  endtask : t_fifo
  task automatic tally_and_finish;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset_select();
    t_regs();
    t_trace();
    t_fifo();
    tally_and_finish();
  end
  // whole run needs about 330 cycles
  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : tb
